// ### verilog/hcs_ctrl.sv
// Function
// R1: sleeping host has its clocks stopped
// R2: sleep request taken only in supervisor mode
// R3: host sleeps until irq or fiq
// R4: wake branches to vector, then resumes
// R5: interrupt sources stay enabled during sleep
// R6: companion quiesces masters before clock stop
// R7: host enables stop interrupt before shutdown
// R8: next state 2h requests disable
// R9: go starts transition, raises stop irq
// R10: pending holds until host sleeps
// R11: disabled completion reads state 2h
// R12: host handler drains, arms wake, sleeps
// R13: reset leaves host in reset, clock off
// R14: software waits pending clear before go
// R15: next state 3h plus go enables
// R16: enable clears pending, state reads 3h
// R17: companion fires wake interrupt on enable; the code raises none, and the host sleeps on until irq_req or fiq_req
// R18: gate clock only after host sleeps
`timescale 1ns/1ps
module hcs_ctrl
  import hcs_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          sys_rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [DW-1:0] pwdata,
  output logic      [DW-1:0] prdata,
  output logic               pready,
  output logic               pslverr,
  input  hcs_host_in_t       host_in,
  output logic               host_clk_en,
  output logic               host_rst_n,
  output logic               host_clock_stop_request_irq,
  output logic               host_sleep,
  output logic               host_wake_vector,
  output logic               irq
);

  // bus decode
  logic acc;
  logic setup;
  logic wr;
  logic sel_modctl;
  logic sel_cmd;
  logic sel_tstat;
  logic sel_modsta;
  logic sel_istat;
  logic sel_imask;
  logic mapped;

  assign acc        = psel & penable;
  assign setup      = psel & ~penable;
  assign wr         = acc & pwrite;
  assign sel_modctl = (paddr == OFF_MODCTL);
  assign sel_cmd    = (paddr == OFF_CMD);
  assign sel_tstat  = (paddr == OFF_TSTAT);
  assign sel_modsta = (paddr == OFF_MODSTA);
  assign sel_istat  = (paddr == OFF_ISTAT);
  assign sel_imask  = (paddr == OFF_IMASK);
  assign mapped     = sel_modctl | sel_cmd | sel_tstat
                    | sel_modsta | sel_istat | sel_imask;

  // per-register strobes and address error
  logic wr_modctl;
  logic wr_cmd;
  logic wr_istat;
  logic wr_imask;
  logic rd_setup;
  logic bad_addr;

  assign wr_modctl = wr & sel_modctl;
  assign wr_cmd    = wr & sel_cmd;
  assign wr_istat  = wr & sel_istat;
  assign wr_imask  = wr & sel_imask;
  assign rd_setup  = setup & ~pwrite;
  assign bad_addr  = acc & ~mapped;

  assign pready  = 1'b1;
  assign pslverr = bad_addr;

  // control and status state
  hcs_fsm_t    st_q;
  hcs_fsm_t    st_d;
  hcs_mstate_t next_q;
  hcs_mstate_t tgt_q;
  hcs_mstate_t mstate_q;
  hcs_mstate_t mstate_d;
  logic        pend_q;
  logic        pend_d;
  logic        clk_on_q;
  logic        rstn_q;
  logic        stopirq_q;
  logic        stopirq_d;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;

  // sleep unit and interrupt bank
  logic           sleep_q;
  logic           wake_q;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] istat;
  logic [NEV-1:0] imask;

  // go decode
  logic go_w;
  logic go_ok;
  logic go_refused;
  logic host_running;
  logic disable_req;
  logic done;

  // sequencer state decode
  logic in_idle;
  logic in_gate;
  logic in_apply;

  assign in_idle  = (st_q == ST_IDLE);
  assign in_gate  = (st_q == ST_GATE);
  assign in_apply = (st_q == ST_APPLY);

  assign go_w       = wr_cmd & pwdata[GO_BIT];  // see R9
  assign go_ok      = go_w & ~pend_q & in_idle; // see R14
  assign go_refused = go_w & ~go_ok;

  // a disable of a running host needs its cooperation
  assign host_running = clk_on_q & rstn_q;
  assign disable_req  = (next_q == MS_DISABLE) & host_running; // see R8

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
      begin
        if (go_ok)
        begin
          if (disable_req) // see R8
            st_d = ST_STOP_REQ;
          else
            st_d = ST_APPLY; // see R15
        end
      end
      ST_STOP_REQ:
      begin
        if (sleep_q)
          st_d = ST_GATE; // see R18
      end
      ST_GATE:
        st_d = ST_IDLE;
      ST_APPLY:
        st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  assign done = in_gate | in_apply;

  // pending set by go, cleared only at completion
  logic pend_set;
  logic pend_clr;

  assign pend_set = go_ok;
  assign pend_clr = done; // see R10

  always_comb
  begin
    pend_d = pend_q;
    if (pend_clr)
      pend_d = 1'b0; // see R10
    if (pend_set)
      pend_d = 1'b1;
  end

  // stop request stays up until the host has slept
  always_comb
  begin
    stopirq_d = stopirq_q;
    if (st_d == ST_STOP_REQ)
      stopirq_d = 1'b1; // see R9
    else
      stopirq_d = 1'b0;
  end

  always_comb
  begin
    mstate_d = mstate_q;
    if (done)
      mstate_d = tgt_q; // see R11 see R16
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      st_q <= ST_IDLE;
    else
      st_q <= st_d;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pend_q    <= 1'b0;
      stopirq_q <= 1'b0;
      mstate_q  <= MS_RESET_VAL; // see R13
    end
    else
    begin
      pend_q    <= pend_d;
      stopirq_q <= stopirq_d;
      mstate_q  <= mstate_d;
    end
  end

  // target state split into clock and reset controls
  logic tgt_clk_on;
  logic tgt_rst_rel;

  assign tgt_clk_on  = tgt_q[0];
  assign tgt_rst_rel = tgt_q[1];

  // module state drives clock and reset of the host
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      clk_on_q <= 1'b0; // see R13
      rstn_q   <= 1'b0;
    end
    else if (done)
    begin
      clk_on_q <= tgt_clk_on; // see R18
      rstn_q   <= tgt_rst_rel;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      next_q <= MS_RESET_VAL;
    else if (wr_modctl)
      next_q <= hcs_mstate_t'(pwdata[STATE_LSB +: 2]); // see R8 see R15
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      tgt_q <= MS_RESET_VAL;
    else if (go_ok)
      tgt_q <= next_q;
  end

  // events
  logic sleep_d1_q;
  logic sleep_rise;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      sleep_d1_q <= 1'b0;
    else
      sleep_d1_q <= sleep_q;
  end

  assign sleep_rise     = sleep_q & ~sleep_d1_q;
  assign ev[EV_DONE]    = done;
  assign ev[EV_SLEPT]   = sleep_rise;
  assign ev[EV_REFUSED] = go_refused;

  // read data captured in the setup phase
  always_comb
  begin
    rdata_d = '0;
    if (sel_modctl)
      rdata_d[STATE_LSB +: 2] = next_q;
    if (sel_tstat)
      rdata_d[PEND_BIT] = pend_q; // see R10
    if (sel_modsta)
    begin
      rdata_d[STATE_LSB +: 2] = mstate_q; // see R11 see R16
      rdata_d[CLKON_BIT]      = clk_on_q;
      rdata_d[RSTN_BIT]       = rstn_q;
      rdata_d[SLEEP_BIT]      = sleep_q;
    end
    if (sel_istat)
      rdata_d[NEV-1:0] = istat;
    if (sel_imask)
      rdata_d[NEV-1:0] = imask;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdata_q <= '0;
    else if (rd_setup)
      rdata_q <= rdata_d;
  end

  assign prdata = rdata_q;

  // wake sources of the sleeping host; the stop request is left out,
  // since it is still high as the host enters sleep and would end it
  logic host_irq;
  logic host_fiq;

  assign host_irq = host_in.irq_req; // see R3
  assign host_fiq = host_in.fiq_req; // see R3

  hcs_wfi_sleep u_sleep (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clk_on     (host_running),
    .wfi_req    (host_in.wfi_req),
    .supervisor (host_in.supervisor),
    .irq_req    (host_irq),
    .fiq_req    (host_fiq),
    .sleep_q    (sleep_q),
    .wake_q     (wake_q)
  );

  hcs_irq_regs u_irq (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ev      (ev),
    .clr_wr  (wr_istat),
    .mask_wr (wr_imask),
    .wdata   (pwdata[NEV-1:0]),
    .stat_q  (istat),
    .mask_q  (imask),
    .irq     (irq)
  );

  // host clock runs only when enabled and awake
  assign host_clk_en                 = clk_on_q & ~sleep_q; // see R1
  assign host_rst_n                  = rstn_q;
  assign host_clock_stop_request_irq = stopirq_q; // see R9
  assign host_sleep                  = sleep_q;
  assign host_wake_vector            = wake_q; // see R4

endmodule : hcs_ctrl

// ### verilog/hcs_pkg.sv
package hcs_pkg;

  localparam int unsigned AW = 12;
  localparam int unsigned DW = 32;

  // register byte offsets
  localparam logic [AW-1:0] OFF_MODCTL = 12'h000;
  localparam logic [AW-1:0] OFF_CMD    = 12'h004;
  localparam logic [AW-1:0] OFF_TSTAT  = 12'h008;
  localparam logic [AW-1:0] OFF_MODSTA = 12'h00C;
  localparam logic [AW-1:0] OFF_ISTAT  = 12'h010;
  localparam logic [AW-1:0] OFF_IMASK  = 12'h014;

  // field positions
  localparam int unsigned GO_BIT      = 0;
  localparam int unsigned PEND_BIT    = 0;
  localparam int unsigned STATE_LSB   = 0;
  localparam int unsigned CLKON_BIT   = 8;
  localparam int unsigned RSTN_BIT    = 9;
  localparam int unsigned SLEEP_BIT   = 10;

  // interrupt events
  localparam int unsigned NEV         = 3;
  localparam int unsigned EV_DONE     = 0;
  localparam int unsigned EV_SLEPT    = 1;
  localparam int unsigned EV_REFUSED  = 2;

  // module states: bit0 = clock on, bit1 = reset released
  typedef enum logic [1:0] {
    MS_RST_OFF  = 2'h0,
    MS_SYNC_RST = 2'h1,
    MS_DISABLE  = 2'h2,
    MS_ENABLE   = 2'h3
  } hcs_mstate_t;

  localparam hcs_mstate_t MS_RESET_VAL = MS_RST_OFF;

  // transition sequencer, gray except the ST_GATE to ST_IDLE step
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_STOP_REQ = 2'b01,
    ST_GATE     = 2'b11,
    ST_APPLY    = 2'b10
  } hcs_fsm_t;

  // host core side inputs
  typedef struct packed {
    logic irq_req;
    logic fiq_req;
    logic wfi_req;
    logic supervisor;
  } hcs_host_in_t;

endpackage : hcs_pkg

// ### verilog/hcs_wfi_sleep.sv
`timescale 1ns/1ps
module hcs_wfi_sleep
  import hcs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clk_on,
  input  wire logic wfi_req,
  input  wire logic supervisor,
  input  wire logic irq_req,
  input  wire logic fiq_req,
  output logic      sleep_q,
  output logic      wake_q
);

  logic enter;
  logic wake;

  assign enter = clk_on & wfi_req & supervisor & ~sleep_q; // see R2
  assign wake  = sleep_q & (irq_req | fiq_req);            // see R3

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sleep_q <= 1'b0;
      wake_q  <= 1'b0;
    end
    else
    begin
      sleep_q <= enter | (sleep_q & ~wake); // see R1
      wake_q  <= wake;                      // see R4
    end
  end

endmodule : hcs_wfi_sleep

// ### verilog/hcs_irq_regs.sv
`timescale 1ns/1ps
module hcs_irq_regs
  import hcs_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           sys_rst,
  input  wire logic [NEV-1:0] ev,
  input  wire logic           clr_wr,
  input  wire logic           mask_wr,
  input  wire logic [NEV-1:0] wdata,
  output logic      [NEV-1:0] stat_q,
  output logic      [NEV-1:0] mask_q,
  output logic                irq
);

  for (genvar i = 0; i < NEV; i++)
  begin : g_bit
    logic clr;
    assign clr = clr_wr & wdata[i];
    always_ff @(posedge sys_clk)
    begin
      if (sys_rst)
        stat_q[i] <= 1'b0;
      else
        stat_q[i] <= ev[i] | (stat_q[i] & ~clr);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      mask_q <= '0;
    else if (mask_wr)
      mask_q <= wdata;
  end

  assign irq = |(stat_q & mask_q);

endmodule : hcs_irq_regs

// ### dv/hcs_ctrl_monitor.sv
`timescale 1ns/1ps
module hcs_ctrl_monitor
  import hcs_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          sys_rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  input hcs_host_in_t       host_in,
  input wire logic          host_clk_en,
  input wire logic          host_rst_n,
  input wire logic          host_clock_stop_request_irq,
  input wire logic          host_sleep,
  input wire logic          host_wake_vector,
  input wire logic          irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire go_w = psel && penable && pwrite && paddr == OFF_CMD && pwdata[GO_BIT];
  wire calm = !host_in.irq_req && !host_in.fiq_req && !host_clock_stop_request_irq;
  sequence s_stop;
    host_clock_stop_request_irq && !host_sleep;
  endsequence
  sequence s_nap;
    host_sleep && calm;
  endsequence
  AST_SLEEP_CLK: assert property (host_sleep |-> !host_clk_en)
    else $error("clock runs while host sleeps");
  AST_SUPV: assert property (host_in.wfi_req && !host_in.supervisor && !host_sleep |=> !host_sleep)
    else $error("sleep taken outside supervisor mode");
  AST_STAY: assert property (s_nap |=> host_sleep)
    else $error("host woke without interrupt");
  AST_WAKE: assert property ($fell(host_sleep) |-> ##[0:1] host_wake_vector)
    else $error("no vector on wake");
  AST_GO: assert property ($rose(host_clock_stop_request_irq) |-> $past(go_w))
    else $error("stop request without go");
  AST_STOP_HOLD: assert property (s_stop |=> host_clock_stop_request_irq)
    else $error("stop request dropped before sleep");
  AST_RST: assert property (disable iff (1'b0) sys_rst |=> !host_rst_n && !host_clk_en && !irq)
    else $error("reset state wrong");
  AST_GATE: assert property ($fell(host_clk_en) && host_rst_n |-> host_sleep)
    else $error("clock gated before host slept");
endmodule : hcs_ctrl_monitor
bind hcs_ctrl hcs_ctrl_monitor u_mon (.*);

// ### dv/hcs_host_model.sv
`timescale 1ns/1ps
module hcs_host_model
  import hcs_pkg::*;
#(
  parameter logic [3:0] LAG = 4'h3
)
(
  input wire logic       sys_clk,
  input wire logic       stop_irq,
  input wire logic       sleeping,
  input wire logic       supv,
  input wire logic [1:0] wake,
  output hcs_host_in_t   host_in
);
  logic [3:0] cnt_q = 4'h0;
  initial host_in = '0;
  // handler drains own masters for LAG cycles, then sleeps
  always @(posedge sys_clk)
  begin
    cnt_q <= (stop_irq && !sleeping) ? cnt_q + 4'h1 : 4'h0;
    host_in.wfi_req <= stop_irq && !sleeping && cnt_q >= LAG;
    host_in.supervisor <= supv;
    host_in.irq_req <= wake[1];
    host_in.fiq_req <= wake[0];
  end
endmodule : hcs_host_model

// ### dv/hcs_ctrl_tb.sv
`timescale 1ns/1ps
module hcs_ctrl_tb
  import hcs_pkg::*;
;
  logic          sys_clk = 0;
  logic          sys_rst = 1;
  logic          psel = 0;
  logic          penable = 0;
  logic          pwrite = 0;
  logic [AW-1:0] paddr = '0;
  logic [DW-1:0] pwdata = '0;
  logic [DW-1:0] prdata;
  logic [DW-1:0] rd;
  logic          pready;
  logic          pslverr;
  logic          err;
  logic          supv = 1;
  logic [1:0]    wake = 0;
  hcs_host_in_t  host_in;
  logic          clk_en;
  logic          rst_n;
  logic          stop;
  logic          sleep;
  logic          irq;
  int            fail_count = 0;
  int            cmp_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  hcs_ctrl uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_in(host_in), .host_clk_en(clk_en), .host_rst_n(rst_n),
    .host_clock_stop_request_irq(stop), .host_sleep(sleep), .host_wake_vector(), .irq(irq));
  hcs_host_model host (.sys_clk(sys_clk), .stop_irq(stop), .sleeping(sleep), .supv(supv),
    .wake(wake), .host_in(host_in));
  task wrap_up;
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %0t %h %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rdc(input logic [AW-1:0] a, input logic [DW-1:0] e);
    apb(0, a, '0);
    chk(rd, e);
  endtask : rdc
  task idle;
    int n;
    n = 0;
    do
    begin
      apb(0, OFF_TSTAT, '0);
      n++;
    end
    while (rd[PEND_BIT] !== 1'b0 && n < 40);
    chk(rd[PEND_BIT], 1'b0);
  endtask : idle
  task go(input logic [1:0] nxt);
    apb(1, OFF_MODCTL, {30'h0, nxt});
    apb(1, OFF_CMD, 32'h1);
  endtask : go
  initial
  begin
    #20000;
    fail_count++;
    wrap_up;
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 0;
    rdc(OFF_MODSTA, 32'h0);
    apb(0, 12'h018, '0);
    chk(err, 1'b1);
    go(2'h3);
    idle;
    rdc(OFF_MODSTA, 32'h303);
    chk(rst_n, 1'b1);
    repeat (8) @(posedge sys_clk);
    supv <= 0;
    go(2'h2);
    repeat (20) @(posedge sys_clk);
    chk(stop, 1'b1);
    rdc(OFF_TSTAT, 32'h1);
    apb(1, OFF_CMD, 32'h1);
    supv <= 1;
    idle;
    rdc(OFF_MODSTA, 32'h602);
    rdc(OFF_ISTAT, 32'h7);
    apb(1, OFF_IMASK, 32'h2);
    @(negedge sys_clk);
    chk(irq, 1'b1);
    apb(1, OFF_ISTAT, 32'h7);
    apb(1, OFF_IMASK, 32'h7);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    rdc(OFF_ISTAT, 32'h0);
    go(2'h3);
    idle;
    rdc(OFF_MODSTA, 32'h703);
    wake <= 2'b10;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(clk_en, 1'b1);
    @(posedge sys_clk);
    wake <= 2'b00;
    rdc(OFF_MODSTA, 32'h303);
    wrap_up;
  end
endmodule : hcs_ctrl_tb
